//--- rtl/prv_pkg.sv
package prv_pkg;

    // Bus and field widths
    localparam int PRV_ADDR_W = 8;
    localparam int PRV_DATA_W = 8;
    localparam int PRV_CODE_W = 7;

    // Register byte offsets
    localparam logic [7:0] PRV_OFS_FORCED_SHUTDOWN_CTRL = 8'h91;
    localparam logic [7:0] PRV_OFS_RAIL2_SLEEP_CTRL = 8'h93;
    localparam logic [7:0] PRV_OFS_RAIL4_VOLTAGE = 8'h94;
    localparam logic [7:0] PRV_OFS_RAIL4_SLEEP_VOLTAGE = 8'h95;
    localparam logic [7:0] PRV_OFS_RAIL5_VOLTAGE = 8'h96;
    localparam logic [7:0] PRV_OFS_RAIL5_SLEEP_VOLTAGE = 8'h97;
    localparam logic [7:0] PRV_OFS_RAIL6_VOLTAGE = 8'h98;

    // Register values after reset
    localparam logic [7:0] PRV_RST_FORCED_SHUTDOWN_CTRL = 8'h00;
    localparam logic [7:0] PRV_RST_RAIL2_SLEEP_CTRL = 8'h50;
    localparam logic [7:0] PRV_RST_RAIL4_VOLTAGE = 8'h20;
    localparam logic [7:0] PRV_RST_RAIL4_SLEEP_VOLTAGE = 8'h20;
    localparam logic [7:0] PRV_RST_RAIL5_VOLTAGE = 8'h70;
    localparam logic [7:0] PRV_RST_RAIL5_SLEEP_VOLTAGE = 8'he8;
    localparam logic [7:0] PRV_RST_RAIL6_VOLTAGE = 8'he8;

    // Field positions
    localparam int PRV_CODE_MSB = 7;
    localparam int PRV_CODE_LSB = 1;
    localparam int PRV_FLAG_BIT = 0;

    // Shutdown pulse length
    localparam int PRV_CLK_MHZ = 100;
    localparam int PRV_SHUTDOWN_HOLD_NS = 100;
    localparam int PRV_SHUTDOWN_HOLD_CYCLES = (PRV_SHUTDOWN_HOLD_NS * PRV_CLK_MHZ + 999) / 1000;
    localparam int PRV_HOLD_CNT_W = 8;

    // Codes below this limit use the fine step, the rest the coarse step
    localparam logic [6:0] PRV_FINE_STEP_LIMIT = 7'h40;
    localparam int PRV_FINE_STEP_MV = 10;
    localparam int PRV_COARSE_STEP_MV = 25;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } prv_bus_req_t;

    typedef struct packed {
        logic [6:0] code;
        logic decay;
        logic fine_step;
    } prv_rail_out_t;

    typedef enum logic [0:0] {
        PRV_RUN,
        PRV_SHUTDOWN
    } prv_state_t;

endpackage

//--- rtl/prv_rail_target.sv
`timescale 1ns/1ns
module prv_rail_target
    import prv_pkg::*;
#(
    parameter logic [6:0] FINE_LIMIT = PRV_FINE_STEP_LIMIT
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [6:0] normal_code,
    input wire logic [6:0] sleep_code,
    input wire logic sleep_active,
    input wire logic decay_select,
    output prv_rail_out_t rail_out
);

    if (FINE_LIMIT == 7'h00) begin : g_chk
        $error("prv_rail_target: FINE_LIMIT must be nonzero");
    end

    logic [6:0] chosen_code;
    logic chosen_fine;
    prv_rail_out_t next_rail_out;

    // Sleep code takes over while the rail is in sleep
    assign chosen_code = sleep_active ? sleep_code : normal_code;
    assign chosen_fine = (chosen_code < FINE_LIMIT);
    assign next_rail_out = '{code: chosen_code, decay: decay_select, fine_step: chosen_fine};

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rail_out <= '0;
        end else begin
            rail_out <= next_rail_out;
        end
    end

endmodule

//--- rtl/prv_regs.sv
`timescale 1ns/1ns
// Overview of operation
// - Writing one to shutdown bit forces shutdown and resets every register; zero does nothing.
// - The shutdown bit clears itself after acting; later reads show zero.
// - Rail-2 sleep control bits 7:1 hold the sleep code, reset 28h.
// - Rail-2 sleep control bit 0 enables sleep, reset zero; factory pin selects sleep.
// - Rail-4 voltage bits 7:1 hold the normal code, reset 10h.
// - Rail-4 sleep voltage bits 7:1 hold the sleep code, reset 10h; bit 0 reads zero.
// - Rail-5 voltage bits 7:1 hold the normal code, reset 38h.
// - Rail-5 sleep voltage bits 7:1 hold the sleep code, reset 74h; bit 0 reads zero.
// - Rail-6 voltage bits 7:1 hold the normal code, reset 74h.
// - Bit 0 of rail 4/5/6 voltage selects slew (0) or free decay (1), reset 0.
// - Voltage codes map to targets in 10 mV or 25 mV step ranges.
// - Shutdown control bits 7:1 are read-only and read zero.
module prv_regs
    import prv_pkg::*;
#(
    parameter int HOLD_CYCLES = PRV_SHUTDOWN_HOLD_CYCLES,
    parameter bit SLEEP_PIN_B = 1'b0,
    parameter logic [6:0] FINE_LIMIT = PRV_FINE_STEP_LIMIT
) (
    input wire logic ref_clk,
    input wire logic rst,
    input prv_bus_req_t bus_req,
    output logic [7:0] reg_rdata,
    input wire logic sleep_select_pin_a,
    input wire logic sleep_select_pin_b,
    input wire logic sleep_state_request,
    input wire logic [6:0] rail2_normal_code,
    output logic force_shutdown,
    output logic rail2_sleep_active,
    output prv_rail_out_t rail2_out,
    output prv_rail_out_t rail4_out,
    output prv_rail_out_t rail5_out,
    output prv_rail_out_t rail6_out
);

    if (HOLD_CYCLES < 1 || HOLD_CYCLES >= (1 << PRV_HOLD_CNT_W)) begin : g_chk
        $error("prv_regs: HOLD_CYCLES out of range");
    end

    localparam logic [PRV_HOLD_CNT_W-1:0] HOLD_LAST = PRV_HOLD_CNT_W'(HOLD_CYCLES - 1);

    // Shutdown sequencer
    prv_state_t state;
    prv_state_t next_state;
    logic [PRV_HOLD_CNT_W-1:0] hold_cnt;
    logic [PRV_HOLD_CNT_W-1:0] next_hold_cnt;
    logic soft_reset;
    logic reg_clear;

    // Stored fields
    logic shutdown_request;
    logic [6:0] rail2_sleep_code;
    logic rail2_sleep_enable;
    logic [6:0] rail4_normal_code;
    logic rail4_decay_select;
    logic [6:0] rail4_sleep_code;
    logic [6:0] rail5_normal_code;
    logic rail5_decay_select;
    logic [6:0] rail5_sleep_code;
    logic [6:0] rail6_normal_code;
    logic rail6_decay_select;

    // Address decode
    logic bus_open;
    logic wr_ok;
    logic hit_shutdown;
    logic hit_rail2_sleep;
    logic hit_rail4;
    logic hit_rail4_sleep;
    logic hit_rail5;
    logic hit_rail5_sleep;
    logic hit_rail6;
    logic wr_shutdown;
    logic wr_rail2_sleep;
    logic wr_rail4;
    logic wr_rail4_sleep;
    logic wr_rail5;
    logic wr_rail5_sleep;
    logic wr_rail6;
    logic [6:0] wr_code;
    logic wr_flag;

    // Read path
    logic [7:0] view_shutdown;
    logic [7:0] view_rail2_sleep;
    logic [7:0] view_rail4;
    logic [7:0] view_rail4_sleep;
    logic [7:0] view_rail5;
    logic [7:0] view_rail5_sleep;
    logic [7:0] view_rail6;
    logic [7:0] read_mux;
    logic [7:0] next_reg_rdata;

    // Sleep selection
    logic chosen_sleep_pin;
    logic next_rail2_sleep_active;

    assign soft_reset = (state == PRV_SHUTDOWN);
    assign reg_clear = rst || soft_reset;

    // Writes are ignored while the forced shutdown is in progress
    assign bus_open = (state == PRV_RUN);
    assign wr_ok = bus_req.wr && bus_open;
    assign hit_shutdown = (bus_req.addr == PRV_OFS_FORCED_SHUTDOWN_CTRL);
    assign hit_rail2_sleep = (bus_req.addr == PRV_OFS_RAIL2_SLEEP_CTRL);
    assign hit_rail4 = (bus_req.addr == PRV_OFS_RAIL4_VOLTAGE);
    assign hit_rail4_sleep = (bus_req.addr == PRV_OFS_RAIL4_SLEEP_VOLTAGE);
    assign hit_rail5 = (bus_req.addr == PRV_OFS_RAIL5_VOLTAGE);
    assign hit_rail5_sleep = (bus_req.addr == PRV_OFS_RAIL5_SLEEP_VOLTAGE);
    assign hit_rail6 = (bus_req.addr == PRV_OFS_RAIL6_VOLTAGE);
    assign wr_shutdown = wr_ok && hit_shutdown;
    assign wr_rail2_sleep = wr_ok && hit_rail2_sleep;
    assign wr_rail4 = wr_ok && hit_rail4;
    assign wr_rail4_sleep = wr_ok && hit_rail4_sleep;
    assign wr_rail5 = wr_ok && hit_rail5;
    assign wr_rail5_sleep = wr_ok && hit_rail5_sleep;
    assign wr_rail6 = wr_ok && hit_rail6;
    assign wr_code = bus_req.wdata[PRV_CODE_MSB:PRV_CODE_LSB];
    assign wr_flag = bus_req.wdata[PRV_FLAG_BIT];

    // Sequencer: a pending request starts a hold of HOLD_CYCLES cycles
    always_comb begin
        next_state = state;
        next_hold_cnt = hold_cnt;
        case (state)
            PRV_RUN: begin
                next_hold_cnt = '0;
                if (shutdown_request) begin
                    next_state = PRV_SHUTDOWN;
                end
            end
            PRV_SHUTDOWN: begin
                if (hold_cnt == HOLD_LAST) begin
                    next_state = PRV_RUN;
                    next_hold_cnt = '0;
                end else begin
                    next_hold_cnt = hold_cnt + 1'b1;
                end
            end
            default: begin
                next_state = PRV_RUN;
                next_hold_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= PRV_RUN;
            hold_cnt <= '0;
            force_shutdown <= 1'b0;
        end else begin
            state <= next_state;
            hold_cnt <= next_hold_cnt;
            force_shutdown <= (next_state == PRV_SHUTDOWN);
        end
    end

    // Shutdown request: only a one is stored, and the shutdown itself clears it
    always_ff @(posedge ref_clk) begin
        if (reg_clear) begin
            shutdown_request <= PRV_RST_FORCED_SHUTDOWN_CTRL[PRV_FLAG_BIT];
        end else if (wr_shutdown && wr_flag) begin
            shutdown_request <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reg_clear) begin
            rail2_sleep_code <= PRV_RST_RAIL2_SLEEP_CTRL[PRV_CODE_MSB:PRV_CODE_LSB];
            rail2_sleep_enable <= PRV_RST_RAIL2_SLEEP_CTRL[PRV_FLAG_BIT];
        end else if (wr_rail2_sleep) begin
            rail2_sleep_code <= wr_code;
            rail2_sleep_enable <= wr_flag;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reg_clear) begin
            rail4_normal_code <= PRV_RST_RAIL4_VOLTAGE[PRV_CODE_MSB:PRV_CODE_LSB];
            rail4_decay_select <= PRV_RST_RAIL4_VOLTAGE[PRV_FLAG_BIT];
        end else if (wr_rail4) begin
            rail4_normal_code <= wr_code;
            rail4_decay_select <= wr_flag;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reg_clear) begin
            rail4_sleep_code <= PRV_RST_RAIL4_SLEEP_VOLTAGE[PRV_CODE_MSB:PRV_CODE_LSB];
        end else if (wr_rail4_sleep) begin
            rail4_sleep_code <= wr_code;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reg_clear) begin
            rail5_normal_code <= PRV_RST_RAIL5_VOLTAGE[PRV_CODE_MSB:PRV_CODE_LSB];
            rail5_decay_select <= PRV_RST_RAIL5_VOLTAGE[PRV_FLAG_BIT];
        end else if (wr_rail5) begin
            rail5_normal_code <= wr_code;
            rail5_decay_select <= wr_flag;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reg_clear) begin
            rail5_sleep_code <= PRV_RST_RAIL5_SLEEP_VOLTAGE[PRV_CODE_MSB:PRV_CODE_LSB];
        end else if (wr_rail5_sleep) begin
            rail5_sleep_code <= wr_code;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reg_clear) begin
            rail6_normal_code <= PRV_RST_RAIL6_VOLTAGE[PRV_CODE_MSB:PRV_CODE_LSB];
            rail6_decay_select <= PRV_RST_RAIL6_VOLTAGE[PRV_FLAG_BIT];
        end else if (wr_rail6) begin
            rail6_normal_code <= wr_code;
            rail6_decay_select <= wr_flag;
        end
    end

    // Register views; reserved bits are constant zero
    assign view_shutdown = {7'h00, shutdown_request};
    assign view_rail2_sleep = {rail2_sleep_code, rail2_sleep_enable};
    assign view_rail4 = {rail4_normal_code, rail4_decay_select};
    assign view_rail4_sleep = {rail4_sleep_code, 1'b0};
    assign view_rail5 = {rail5_normal_code, rail5_decay_select};
    assign view_rail5_sleep = {rail5_sleep_code, 1'b0};
    assign view_rail6 = {rail6_normal_code, rail6_decay_select};

    always_comb begin
        case (bus_req.addr)
            PRV_OFS_FORCED_SHUTDOWN_CTRL: read_mux = view_shutdown;
            PRV_OFS_RAIL2_SLEEP_CTRL: read_mux = view_rail2_sleep;
            PRV_OFS_RAIL4_VOLTAGE: read_mux = view_rail4;
            PRV_OFS_RAIL4_SLEEP_VOLTAGE: read_mux = view_rail4_sleep;
            PRV_OFS_RAIL5_VOLTAGE: read_mux = view_rail5;
            PRV_OFS_RAIL5_SLEEP_VOLTAGE: read_mux = view_rail5_sleep;
            PRV_OFS_RAIL6_VOLTAGE: read_mux = view_rail6;
            default: read_mux = 8'h00;
        endcase
    end

    // Read data stands for exactly one cycle after the strobe
    assign next_reg_rdata = bus_req.rd ? read_mux : 8'h00;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

    // Rail 2 follows the factory-chosen sleep pin only when sleep is enabled
    assign chosen_sleep_pin = SLEEP_PIN_B ? sleep_select_pin_b : sleep_select_pin_a;
    assign next_rail2_sleep_active = rail2_sleep_enable && chosen_sleep_pin;

    always_ff @(posedge ref_clk) begin
        if (reg_clear) begin
            rail2_sleep_active <= 1'b0;
        end else begin
            rail2_sleep_active <= next_rail2_sleep_active;
        end
    end

    prv_rail_target #(.FINE_LIMIT(FINE_LIMIT)) u_rail2 (
        .ref_clk(ref_clk),
        .rst(rst),
        .normal_code(rail2_normal_code),
        .sleep_code(rail2_sleep_code),
        .sleep_active(next_rail2_sleep_active),
        .decay_select(1'b0),
        .rail_out(rail2_out)
    );

    prv_rail_target #(.FINE_LIMIT(FINE_LIMIT)) u_rail4 (
        .ref_clk(ref_clk),
        .rst(rst),
        .normal_code(rail4_normal_code),
        .sleep_code(rail4_sleep_code),
        .sleep_active(sleep_state_request),
        .decay_select(rail4_decay_select),
        .rail_out(rail4_out)
    );

    prv_rail_target #(.FINE_LIMIT(FINE_LIMIT)) u_rail5 (
        .ref_clk(ref_clk),
        .rst(rst),
        .normal_code(rail5_normal_code),
        .sleep_code(rail5_sleep_code),
        .sleep_active(sleep_state_request),
        .decay_select(rail5_decay_select),
        .rail_out(rail5_out)
    );

    // Rail 6 sleep code lives outside this bank; the normal code is used throughout
    prv_rail_target #(.FINE_LIMIT(FINE_LIMIT)) u_rail6 (
        .ref_clk(ref_clk),
        .rst(rst),
        .normal_code(rail6_normal_code),
        .sleep_code(rail6_normal_code),
        .sleep_active(1'b0),
        .decay_select(rail6_decay_select),
        .rail_out(rail6_out)
    );

endmodule

//--- verification/prv_regs_asserts.sv
`timescale 1ns/1ns
module prv_regs_asserts
    import prv_pkg::*;
#(
    parameter int HOLD_CYCLES = PRV_SHUTDOWN_HOLD_CYCLES,
    parameter bit SLEEP_PIN_B = 1'b0,
    parameter logic [6:0] FINE_LIMIT = PRV_FINE_STEP_LIMIT
) (
    input wire logic ref_clk,
    input wire logic rst,
    input prv_bus_req_t bus_req,
    input wire logic [7:0] reg_rdata,
    input wire logic sleep_select_pin_a,
    input wire logic sleep_select_pin_b,
    input wire logic force_shutdown,
    input wire logic rail2_sleep_active,
    input prv_rail_out_t rail4_out,
    input prv_rail_out_t rail5_out
);
    logic [7:0] high_cnt;
    wire sd_set = bus_req.wr && bus_req.addr == 8'h91 && bus_req.wdata[0];
    wire rd_sd = bus_req.rd && bus_req.addr == 8'h91;
    wire rd_hole = bus_req.rd && !(bus_req.addr inside {8'h91, [8'h93:8'h98]});
    wire pin_sel = SLEEP_PIN_B ? sleep_select_pin_b : sleep_select_pin_a;
    wire wd0 = bus_req.wdata[0];
    // Counts how many cycles the shutdown pulse has been high
    always_ff @(posedge ref_clk) begin
        high_cnt <= (rst || !force_shutdown) ? 8'h00 : high_cnt + 8'h01;
    end
    default clocking chk_cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    rdata_idle_a: assert property (!$past(bus_req.rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read answer");
    unmapped_read_a: assert property (rd_hole |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    sd_reserved_a: assert property (rd_sd |=> reg_rdata[7:1] == 7'h00)
        else $error("shutdown reserved bits not zero");
    self_clear_a: assert property (rd_sd && !force_shutdown && !$past(sd_set)
        && !$past(sd_set, 2) |=> reg_rdata[0] == 1'b0)
        else $error("shutdown bit did not clear");
    shutdown_start_a: assert property (sd_set && !force_shutdown |-> ##2 force_shutdown)
        else $error("shutdown not started");
    shutdown_len_a: assert property ($fell(force_shutdown) |-> high_cnt == HOLD_CYCLES)
        else $error("shutdown pulse length wrong");
    shutdown_max_a: assert property (force_shutdown |-> high_cnt < HOLD_CYCLES)
        else $error("shutdown pulse too long");
    sleep_pin_a: assert property (!pin_sel |=> !rail2_sleep_active)
        else $error("sleep active without chosen pin");
    sleep_off_a: assert property (bus_req.wr && bus_req.addr == 8'h93 && !wd0
        && !force_shutdown |-> ##2 !rail2_sleep_active)
        else $error("sleep active after disable");
    decay_follow_a: assert property (bus_req.wr && bus_req.addr == 8'h94 && !force_shutdown
        |-> ##2 rail4_out.decay == $past(wd0, 2))
        else $error("decay bit not applied");
    fine_step_a: assert property (!$past(rst)
        |-> rail5_out.fine_step == (rail5_out.code < FINE_LIMIT))
        else $error("step range flag wrong");
endmodule
bind prv_regs prv_regs_asserts #(
    .HOLD_CYCLES(HOLD_CYCLES),
    .SLEEP_PIN_B(SLEEP_PIN_B),
    .FINE_LIMIT(FINE_LIMIT)
) i_chk (
    .ref_clk(ref_clk),
    .rst(rst),
    .bus_req(bus_req),
    .reg_rdata(reg_rdata),
    .sleep_select_pin_a(sleep_select_pin_a),
    .sleep_select_pin_b(sleep_select_pin_b),
    .force_shutdown(force_shutdown),
    .rail2_sleep_active(rail2_sleep_active),
    .rail4_out(rail4_out),
    .rail5_out(rail5_out)
);

//--- verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import prv_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    prv_bus_req_t bus_req = '0;
    logic pin_a = 1'b0;
    logic pin_b = 1'b0;
    logic sleep_req = 1'b0;
    logic [6:0] rail2_normal = 7'h11;
    logic [7:0] reg_rdata;
    logic force_shutdown;
    logic rail2_sleep_active;
    prv_rail_out_t rail2_out, rail4_out, rail5_out, rail6_out;
    int errors = 0;
    int comparisons = 0;
    logic [7:0] ofs [7] = '{8'h91, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97, 8'h98};
    logic [7:0] rstv [7] = '{8'h00, 8'h50, 8'h20, 8'h20, 8'h70, 8'he8, 8'he8};
    logic [7:0] msk [7] = '{8'h00, 8'hff, 8'hff, 8'hfe, 8'hff, 8'hfe, 8'hff};
    logic [7:0] pat [2] = '{8'hff, 8'h2b};
    always #5 ref_clk = ~ref_clk;
    prv_regs #(.HOLD_CYCLES(4)) i_dut (
        .ref_clk(ref_clk),
        .rst(rst),
        .bus_req(bus_req),
        .reg_rdata(reg_rdata),
        .sleep_select_pin_a(pin_a),
        .sleep_select_pin_b(pin_b),
        .sleep_state_request(sleep_req),
        .rail2_normal_code(rail2_normal),
        .force_shutdown(force_shutdown),
        .rail2_sleep_active(rail2_sleep_active),
        .rail2_out(rail2_out),
        .rail4_out(rail4_out),
        .rail5_out(rail5_out),
        .rail6_out(rail6_out)
    );
    task automatic print_verdict;
        $display("Comparisons %0d, errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1;
        check({8'h00, reg_rdata}, {8'h00, exp});
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    initial begin
        #100000;
        errors++;
        print_verdict();
    end
    initial begin
        int n;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) rd(ofs[i], rstv[i]);
        wr(8'h92, 8'hff);
        rd(8'h92, 8'h00);
        for (int p = 0; p < 2; p++) begin
            for (int i = 1; i < 7; i++) begin
                wr(ofs[i], pat[p]);
                rd(ofs[i], pat[p] & msk[i]);
            end
        end
        wr(8'h94, 8'h21);
        wr(8'h95, 8'h80);
        @(posedge ref_clk);
        sleep_req <= 1'b1;
        pin_a <= 1'b1;
        idle(3);
        check({7'h00, rail4_out}, {7'h00, 7'h40, 1'b1, 1'b0});
        check({7'h00, rail5_out}, {7'h00, 7'h15, 1'b1, 1'b1});
        check({7'h00, rail6_out}, {7'h00, 7'h15, 1'b1, 1'b1});
        check({15'h0000, rail2_sleep_active}, 16'h0001);
        check({7'h00, rail2_out}, {7'h00, 7'h15, 1'b0, 1'b1});
        @(posedge ref_clk);
        sleep_req <= 1'b0;
        pin_a <= 1'b0;
        pin_b <= 1'b1;
        idle(3);
        check({7'h00, rail4_out}, {7'h00, 7'h10, 1'b1, 1'b1});
        check({15'h0000, rail2_sleep_active}, 16'h0000);
        check({7'h00, rail2_out}, {7'h00, 7'h11, 1'b0, 1'b1});
        // Sleep disabled: the chosen pin alone must not put rail 2 to sleep
        wr(8'h93, 8'h2a);
        pin_a <= 1'b1;
        idle(2);
        check({15'h0000, rail2_sleep_active}, 16'h0000);
        wr(8'h91, 8'hfe);
        idle(4);
        check({15'h0000, force_shutdown}, 16'h0000);
        rd(8'h94, 8'h21);
        wr(8'h91, 8'hff);
        // Lands while the shutdown pulse is high, so it must be dropped
        wr(8'h94, 8'h00);
        n = 0;
        while (force_shutdown !== 1'b0 && n < 50) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check({15'h0000, force_shutdown}, 16'h0000);
        for (int i = 0; i < 7; i++) rd(ofs[i], rstv[i]);
        print_verdict();
    end
endmodule
